// ---- rtl/stt_pkg.sv ----
package stt_pkg;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_CTRL0 = 3'h0;
    localparam logic [2:0] ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] ADDR_CNT_LO = 3'h2;
    localparam logic [2:0] ADDR_CNT_HI = 3'h3;
    localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
    localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
    localparam logic [2:0] ADDR_PINSEL = 3'h6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [3:0] PINSEL_RST = 4'h0;
    localparam logic [9:0] CMPA_RST = 10'h000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int C0_PAUSE = 7;
    localparam int C0_CKSEL_HI = 6;
    localparam int C0_CKSEL_LO = 4;
    localparam int C0_ON = 3;
    localparam int C0_PER_HI = 2;
    localparam int C0_PER_LO = 0;
    localparam int C1_MODE_HI = 7;
    localparam int C1_MODE_LO = 6;
    localparam int C1_IO_HI = 5;
    localparam int C1_IO_LO = 4;
    localparam int C1_INIT = 3;
    localparam int C1_POL = 2;
    localparam int C1_CLRSRC = 0;
    localparam int PS_OUT = 0;
    localparam int PS_INV = 1;
    localparam int PS_EXTCK = 2;
    localparam int PS_CAP = 3;
    localparam int PER_SHIFT = 7;

    // ------------------------------------------------------------
    // clock select codes and dividers
    // ------------------------------------------------------------
    localparam logic [2:0] CK_SYS4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_HIGH16 = 3'h2;
    localparam logic [2:0] CK_HIGH64 = 3'h3;
    localparam logic [2:0] CK_TB0 = 3'h4;
    localparam logic [2:0] CK_TB1 = 3'h5;
    localparam logic [2:0] CK_EXT_RISE = 3'h6;
    localparam logic [2:0] CK_EXT_FALL = 3'h7;
    localparam logic [1:0] SYS4_LAST = 2'h3;
    localparam logic [5:0] HIGH16_MASK = 6'h0F;
    localparam logic [5:0] HIGH64_LAST = 6'h3F;

    // ------------------------------------------------------------
    // modes and pin functions
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_CMP = 2'b00,
        MODE_CAP = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TMR = 2'b11
    } stt_mode_type;

    localparam logic [1:0] IO_NONE = 2'h0;
    localparam logic [1:0] IO_LOW = 2'h1;
    localparam logic [1:0] IO_HIGH = 2'h2;
    localparam logic [1:0] IO_TOGGLE = 2'h3;
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;
    localparam logic [1:0] CAP_BOTH = 2'h2;

endpackage

// ---- rtl/stt_edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module stt_edge_sync (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // pin
    input wire logic i_pin,
    // edge events
    output logic o_rise,
    output logic o_fall
);
    logic meta;
    logic sync;
    logic prev;
    logic next_rise;
    logic next_fall;

    always_comb begin
        next_rise = sync & ~prev;
        next_fall = ~sync & prev;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else begin
            meta <= i_pin;
            sync <= meta;
            prev <= sync;
            o_rise <= next_rise;
            o_fall <= next_fall;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/stt_clk_sel.sv ----
`timescale 1ns/1ps
`default_nettype none
module stt_clk_sel (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // selection
    input wire logic [2:0] i_sel,
    input wire logic i_ext_en,
    // sources
    input wire logic i_high_tick,
    input wire logic i_tb_tick,
    input wire logic i_ext_rise,
    input wire logic i_ext_fall,
    // counting tick
    output logic o_tick
);
    logic [1:0] div4;
    logic [5:0] div64;
    logic [1:0] next_div4;
    logic [5:0] next_div64;
    logic next_tick;

    always_comb begin
        next_div4 = div4 + 2'h1;
        next_div64 = i_high_tick ? div64 + 6'h01 : div64;
        case (i_sel)
            stt_pkg::CK_SYS4: next_tick = (div4 == stt_pkg::SYS4_LAST);
            stt_pkg::CK_SYS: next_tick = 1'b1;
            stt_pkg::CK_HIGH16: begin
                next_tick = i_high_tick
                    & ((div64 & stt_pkg::HIGH16_MASK) == stt_pkg::HIGH16_MASK);
            end
            stt_pkg::CK_HIGH64: next_tick = i_high_tick & (div64 == stt_pkg::HIGH64_LAST);
            stt_pkg::CK_TB0, stt_pkg::CK_TB1: next_tick = i_tb_tick;
            stt_pkg::CK_EXT_RISE: next_tick = i_ext_en & i_ext_rise;
            stt_pkg::CK_EXT_FALL: next_tick = i_ext_en & i_ext_fall;
            default: next_tick = 1'b0;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div4 <= 2'h0;
            div64 <= 6'h00;
            o_tick <= 1'b0;
        end else begin
            div4 <= next_div4;
            div64 <= next_div64;
            o_tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/stt_timer.sv ----
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module stt_timer (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // clock sources and input pins
    input wire logic i_high_tick,
    input wire logic i_timebase_tick,
    input wire logic i_external_clock_pin,
    input wire logic i_capture_input_pin,
    // match and capture requests
    output logic o_irq_a,
    output logic o_irq_p,
    // output pins
    output logic o_timer_output_pin,
    output logic o_timer_output_oe,
    output logic o_inverted_output_pin,
    output logic o_inverted_output_oe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [3:0] pinsel;
    logic [9:0] cmpa;
    logic [9:0] cnt;
    logic [7:0] hold;
    logic on_d;
    logic lvl;
    logic [7:0] next_ctrl0;
    logic [7:0] next_ctrl1;
    logic [3:0] next_pinsel;
    logic [9:0] next_cmpa;
    logic [9:0] next_cnt;
    logic [7:0] next_hold;
    logic [7:0] next_rdata;
    logic next_lvl;
    logic next_irq_a;
    logic next_irq_p;

    // ------------------------------------------------------------
    // decoded fields
    // ------------------------------------------------------------
    logic ctrl_on;
    logic run;
    logic on_rise;
    logic tick;
    logic [2:0] per;
    logic [1:0] io;
    logic init_lvl;
    logic clr_src;
    stt_pkg::stt_mode_type mode;
    logic [9:0] inc;
    logic hit_a;
    logic hit_p;
    logic cap_ev;
    logic ext_rise;
    logic ext_fall;
    logic cap_rise;
    logic cap_fall;
    logic wr_hi_a;

    assign ctrl_on = ctrl0[stt_pkg::C0_ON];
    assign run = ctrl_on & ~ctrl0[stt_pkg::C0_PAUSE];
    assign on_rise = ctrl_on & ~on_d;
    assign per = ctrl0[stt_pkg::C0_PER_HI:stt_pkg::C0_PER_LO];
    assign io = ctrl1[stt_pkg::C1_IO_HI:stt_pkg::C1_IO_LO];
    assign init_lvl = ctrl1[stt_pkg::C1_INIT];
    assign clr_src = ctrl1[stt_pkg::C1_CLRSRC];
    assign mode = stt_pkg::stt_mode_type'(ctrl1[stt_pkg::C1_MODE_HI:stt_pkg::C1_MODE_LO]);
    assign inc = cnt + 10'h001;
    assign wr_hi_a = i_wr && (i_addr == stt_pkg::ADDR_CMPA_HI);

    // ------------------------------------------------------------
    // pin edges and counting clock
    // ------------------------------------------------------------
    stt_edge_sync u_ext_sync (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_pin(i_external_clock_pin),
        .o_rise(ext_rise),
        .o_fall(ext_fall)
    );

    stt_edge_sync u_cap_sync (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_pin(i_capture_input_pin),
        .o_rise(cap_rise),
        .o_fall(cap_fall)
    );

    stt_clk_sel u_clk_sel (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_sel(ctrl0[stt_pkg::C0_CKSEL_HI:stt_pkg::C0_CKSEL_LO]),
        .i_ext_en(pinsel[stt_pkg::PS_EXTCK]),
        .i_high_tick(i_high_tick),
        .i_tb_tick(i_timebase_tick),
        .i_ext_rise(ext_rise),
        .i_ext_fall(ext_fall),
        .o_tick(tick)
    );

    // ------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------
    // full ten-bit compare
    // capture mode reuses compare A as the capture store, so no A compare there
    assign hit_a = run & tick & (inc == cmpa) & (mode != stt_pkg::MODE_CAP);
    assign hit_p = run & tick & (inc == {per, 7'h00});

    always_comb begin
        cap_ev = 1'b0;
        if (ctrl_on && pinsel[stt_pkg::PS_CAP] && mode == stt_pkg::MODE_CAP) begin
            case (io)
                stt_pkg::CAP_RISE: cap_ev = cap_rise;
                stt_pkg::CAP_FALL: cap_ev = cap_fall;
                stt_pkg::CAP_BOTH: cap_ev = cap_rise | cap_fall;
                default: cap_ev = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_comb begin
        next_cnt = cnt;
        if (on_rise) begin
            next_cnt = 10'h000;
        end else if (run && tick) begin
            if (clr_src ? hit_a : hit_p) begin
                next_cnt = 10'h000;
            end else begin
                next_cnt = inc;
            end
        end
    end

    // ------------------------------------------------------------
    // output level
    // ------------------------------------------------------------
    // compare and PWM modes drive the level; capture and timer modes hold it
    always_comb begin
        next_lvl = lvl;
        case (mode)
            stt_pkg::MODE_CMP: begin
                if (on_rise) begin
                    next_lvl = init_lvl;
                end else if (hit_a) begin
                    case (io)
                        stt_pkg::IO_LOW: next_lvl = 1'b0;
                        stt_pkg::IO_HIGH: next_lvl = 1'b1;
                        stt_pkg::IO_TOGGLE: next_lvl = ~lvl;
                        default: next_lvl = lvl;
                    endcase
                end
            end
            stt_pkg::MODE_PWM: begin
                case (io)
                    stt_pkg::IO_NONE: next_lvl = ~init_lvl;
                    stt_pkg::IO_LOW: next_lvl = init_lvl;
                    stt_pkg::IO_HIGH: begin
                        next_lvl = ctrl_on & (next_cnt < cmpa) ? init_lvl : ~init_lvl;
                    end
                    default: begin
                        // single pulse: active from start until match A
                        if (on_rise) begin
                            next_lvl = init_lvl;
                        end else if (hit_a) begin
                            next_lvl = ~init_lvl;
                        end
                    end
                endcase
            end
            default: next_lvl = lvl;
        endcase
    end

    // ------------------------------------------------------------
    // register writes and byte buffer
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl0 = ctrl0;
        next_ctrl1 = ctrl1;
        next_pinsel = pinsel;
        next_cmpa = cmpa;
        next_hold = hold;
        if (i_wr) begin
            case (i_addr)
                stt_pkg::ADDR_CTRL0: next_ctrl0 = i_wdata;
                stt_pkg::ADDR_CTRL1: next_ctrl1 = i_wdata;
                stt_pkg::ADDR_PINSEL: next_pinsel = i_wdata[3:0];
                stt_pkg::ADDR_CMPA_LO: next_hold = i_wdata;
                stt_pkg::ADDR_CMPA_HI: next_cmpa = {i_wdata[1:0], hold};
                default: next_hold = hold;
            endcase
        end else if (i_rd) begin
            case (i_addr)
                stt_pkg::ADDR_CNT_HI: next_hold = cnt[7:0];
                stt_pkg::ADDR_CMPA_HI: next_hold = cmpa[7:0];
                default: next_hold = hold;
            endcase
        end
        // a software write of compare A in the same cycle beats a capture
        if (cap_ev && !wr_hi_a) begin
            next_cmpa = cnt;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                stt_pkg::ADDR_CTRL0: next_rdata = ctrl0;
                stt_pkg::ADDR_CTRL1: next_rdata = ctrl1;
                stt_pkg::ADDR_CNT_LO: next_rdata = hold;
                stt_pkg::ADDR_CNT_HI: next_rdata = {6'h00, cnt[9:8]};
                stt_pkg::ADDR_CMPA_LO: next_rdata = hold;
                stt_pkg::ADDR_CMPA_HI: next_rdata = {6'h00, cmpa[9:8]};
                stt_pkg::ADDR_PINSEL: next_rdata = {4'h0, pinsel};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_comb begin
        next_irq_a = hit_a | cap_ev;
        next_irq_p = hit_p;
    end

    // ------------------------------------------------------------
    // flops
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl0 <= stt_pkg::CTRL0_RST;
            ctrl1 <= stt_pkg::CTRL1_RST;
            pinsel <= stt_pkg::PINSEL_RST;
            cmpa <= stt_pkg::CMPA_RST;
            cnt <= 10'h000;
            hold <= 8'h00;
            on_d <= 1'b0;
            lvl <= 1'b0;
            o_rdata <= 8'h00;
            o_irq_a <= 1'b0;
            o_irq_p <= 1'b0;
            o_timer_output_pin <= 1'b0;
            o_timer_output_oe <= 1'b0;
            o_inverted_output_pin <= 1'b1;
            o_inverted_output_oe <= 1'b0;
        end else begin
            ctrl0 <= next_ctrl0;
            ctrl1 <= next_ctrl1;
            pinsel <= next_pinsel;
            cmpa <= next_cmpa;
            cnt <= next_cnt;
            hold <= next_hold;
            on_d <= ctrl_on;
            lvl <= next_lvl;
            o_rdata <= next_rdata;
            o_irq_a <= next_irq_a;
            o_irq_p <= next_irq_p;
            o_timer_output_pin <= next_lvl ^ ctrl1[stt_pkg::C1_POL];
            o_timer_output_oe <= pinsel[stt_pkg::PS_OUT];
            o_inverted_output_pin <= ~(next_lvl ^ ctrl1[stt_pkg::C1_POL]);
            o_inverted_output_oe <= pinsel[stt_pkg::PS_INV];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_low_write;
        i_wr && i_addr == stt_pkg::ADDR_CMPA_LO;
    endsequence

    sequence s_high_write;
        i_wr && i_addr == stt_pkg::ADDR_CMPA_HI && !cap_ev;
    endsequence

    a_on_clears_cnt: assert property ($rose(ctrl_on) |=> cnt == 10'h000)
        else $error("counter not cleared when switched on");
    a_off_holds_cnt: assert property (!ctrl_on && !on_rise |=> $stable(cnt))
        else $error("counter moved while off");
    a_cnt_steps_one: assert property (run && tick && !on_rise && !hit_a && !hit_p
        |=> cnt == $past(cnt) + 10'h001)
        else $error("counter did not step by one");
    a_p_clear_cnt: assert property (hit_p && !clr_src && !on_rise
        |=> cnt == 10'h000 ##0 o_irq_p)
        else $error("period match did not clear and request");
    a_a_request: assert property (hit_a |=> o_irq_a && !$past(o_irq_a) || o_irq_a)
        else $error("match A request missing");
    a_pair_write: assert property (s_low_write ##1 s_high_write
        |=> cmpa == {$past(i_wdata[1:0]), $past(i_wdata, 2)})
        else $error("compare pair write wrong");
    a_hi_read_latch: assert property (i_rd && i_addr == stt_pkg::ADDR_CNT_HI && !i_wr
        |=> hold == $past(cnt[7:0]) && o_rdata == {6'h00, $past(cnt[9:8])})
        else $error("high read did not latch low byte");
    a_toggle_out: assert property (mode == stt_pkg::MODE_CMP && io == stt_pkg::IO_TOGGLE
        && hit_a && !on_rise |=> lvl != $past(lvl))
        else $error("compare toggle failed");
    a_idle_no_tick: assert property (!ctrl_on ##1 !ctrl_on |=> !o_irq_a && !o_irq_p)
        else $error("request while counter off");
endmodule
`default_nettype wire

// ---- verification/stt_pin_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module stt_pin_partner (
    // clock
    input wire logic i_sys_clk,
    // timer pins
    input wire logic i_out,
    input wire logic i_out_oe,
    output logic o_ext_clk,
    output logic o_cap,
    output logic o_pad
);
    // ----------------------------------------
    // pad and input pins
    // ----------------------------------------
    // pad keeps its pulled-up alternate use
    assign o_pad = i_out_oe ? i_out : 1'b1;
    initial begin
        o_ext_clk = 1'b0;
        o_cap = 1'b0;
    end
    // slow edges so each one is seen once
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge i_sys_clk) o_ext_clk <= 1'b1;
            repeat (6) @(posedge i_sys_clk);
            o_ext_clk <= 1'b0;
            repeat (6) @(posedge i_sys_clk);
        end
    endtask
    // level held long enough to cross the synchroniser
    task automatic set_cap(input logic v);
        @(posedge i_sys_clk) o_cap <= v;
        repeat (10) @(posedge i_sys_clk);
    endtask
endmodule
`default_nettype wire

// ---- verification/standard_timer_10bit_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module standard_timer_10bit_tb_top;
    typedef struct {logic [2:0] sel; logic [2:0] per; logic [15:0] cyc;} stt_row_type;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic tb_tick = 1'b0;
    logic [7:0] rdata;
    logic ext_clk, cap, irq_a, irq_p, out, out_oe, inv, inv_oe, pad;
    logic [7:0] v;
    logic [9:0] c;
    logic lv;
    int miscompares = 0;
    int tests_run = 0;
    int n_a = 0;
    int n_hi = 0;
    int n, k;
    // mode rows: control word, level after start, level after match A
    logic [7:0] mcfg [6] = '{8'h88, 8'h98, 8'hB8, 8'h18, 8'h20, 8'hC8};
    logic [5:0] mpre = 6'b101110;
    logic [5:0] mpost = 6'b110010;
    stt_row_type rows [13] = '{'{3'h1, 3'h0, 16'h400}, '{3'h1, 3'h1, 16'h080},
        '{3'h1, 3'h2, 16'h100}, '{3'h1, 3'h3, 16'h180}, '{3'h1, 3'h4, 16'h200},
        '{3'h1, 3'h5, 16'h280}, '{3'h1, 3'h6, 16'h300}, '{3'h1, 3'h7, 16'h380},
        '{3'h0, 3'h1, 16'h200}, '{3'h2, 3'h1, 16'h1000}, '{3'h3, 3'h1, 16'h4000},
        '{3'h4, 3'h1, 16'h100}, '{3'h5, 3'h1, 16'h100}};
    // ----------------------------------------
    // clock, ticks and event counters
    // ----------------------------------------
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        tb_tick <= ~tb_tick;
        if (irq_a === 1'b1) n_a <= n_a + 1;
        if (out === 1'b1) n_hi <= n_hi + 1;
    end
    // high clock ticks every other cycle, like the timebase, so the prescaler really waits
    stt_timer DUT (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_high_tick(tb_tick), .i_timebase_tick(tb_tick),
        .i_external_clock_pin(ext_clk), .i_capture_input_pin(cap), .o_irq_a(irq_a),
        .o_irq_p(irq_p), .o_timer_output_pin(out), .o_timer_output_oe(out_oe),
        .o_inverted_output_pin(inv), .o_inverted_output_oe(inv_oe));
    stt_pin_partner PARTNER (.i_sys_clk(sys_clk), .i_out(out), .i_out_oe(out_oe),
        .o_ext_clk(ext_clk), .o_cap(cap), .o_pad(pad));
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    // compare pair written low then high with no gap between the strobes
    task automatic wr_pair(input logic [7:0] lo, input logic [7:0] hi);
        @(posedge sys_clk);
        addr <= stt_pkg::ADDR_CMPA_LO;
        wdata <= lo;
        wr <= 1'b1;
        @(posedge sys_clk);
        addr <= stt_pkg::ADDR_CMPA_HI;
        wdata <= hi;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_cnt(output logic [9:0] r);
        rd_reg(stt_pkg::ADDR_CNT_HI, v);
        r[9:8] = v[1:0];
        rd_reg(stt_pkg::ADDR_CNT_LO, v);
        r[7:0] = v;
    endtask
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", s, e, g);
            miscompares++;
        end
    endtask
    // cycles until the chosen request pulses, bounded
    task automatic gap(input bit pick, output int m);
        m = 0;
        do begin
            @(posedge sys_clk);
            #1 m++;
        end while (((pick ? irq_a : irq_p) !== 1'b1) && m < 20000);
    endtask
    task automatic final_report;
        if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge sys_clk);
        miscompares++;
        final_report();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        addr <= 3'h0;
        wdata <= 8'h00;
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk("reset pins", 16'h0008, 16'({out, out_oe, inv, inv_oe, irq_a, irq_p}));
        resetn <= 1'b1;
        wr_pair(8'h5A, 8'hFE);
        rd_reg(stt_pkg::ADDR_CMPA_HI, v);
        chk("cmpa high", 16'h0002, 16'(v));
        rd_reg(stt_pkg::ADDR_CMPA_LO, v);
        chk("cmpa low", 16'h005A, 16'(v));
        wr_reg(stt_pkg::ADDR_CNT_HI, 8'h03);
        rd_cnt(c);
        chk("counter load", 16'h0000, 16'(c));
        rd_reg(3'h7, v);
        chk("unmapped", 16'h0000, 16'(v));
        foreach (rows[i]) begin
            wr_reg(stt_pkg::ADDR_CTRL0, 8'h00);
            wr_reg(stt_pkg::ADDR_CTRL0, {1'b0, rows[i].sel, 1'b1, rows[i].per});
            gap(1'b0, n);
            gap(1'b0, n);
            chk("period", rows[i].cyc, 16'(n));
        end
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h00);
        wr_reg(stt_pkg::ADDR_PINSEL, 8'h04);
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h68);
        PARTNER.pulse(5);
        rd_cnt(c);
        chk("rise count", 16'h0005, 16'(c));
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h78);
        PARTNER.pulse(3);
        rd_cnt(c);
        chk("fall count", 16'h0008, 16'(c));
        wr_reg(stt_pkg::ADDR_CTRL0, 8'hF8);
        PARTNER.pulse(2);
        rd_cnt(c);
        chk("paused", 16'h0008, 16'(c));
        wr_reg(stt_pkg::ADDR_PINSEL, 8'h00);
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h78);
        PARTNER.pulse(2);
        rd_cnt(c);
        chk("pin unselected", 16'h0008, 16'(c));
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h70);
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h78);
        rd_cnt(c);
        chk("on clears", 16'h0000, 16'(c));
        wr_pair(8'h05, 8'h00);
        wr_reg(stt_pkg::ADDR_CTRL1, 8'h39);
        wr_reg(stt_pkg::ADDR_PINSEL, 8'h03);
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h00);
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h18);
        gap(1'b1, n);
        gap(1'b1, n);
        chk("a period", 16'h0005, 16'(n));
        repeat (2) @(posedge sys_clk);
        #1 lv = out;
        gap(1'b1, n);
        repeat (2) @(posedge sys_clk);
        #1 chk("toggle", 16'(!lv), 16'(out));
        chk("pins", 16'h000B, 16'({inv ^ out, pad ^ out, inv_oe, out_oe}));
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h00);
        wr_reg(stt_pkg::ADDR_PINSEL, 8'h08);
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h68);
        for (int io = 0; io < 4; io++) begin
            wr_reg(stt_pkg::ADDR_CTRL1, {stt_pkg::MODE_CAP, 2'(io), 4'h0});
            k = n_a;
            PARTNER.set_cap(1'b1);
            chk("capture rise", 16'(io == 0 || io == 2), 16'(n_a - k));
            k = n_a;
            PARTNER.set_cap(1'b0);
            chk("capture fall", 16'(io == 1 || io == 2), 16'(n_a - k));
        end
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h00);
        wr_pair(8'h20, 8'h00);
        wr_reg(stt_pkg::ADDR_CTRL1, 8'hA8);
        wr_reg(stt_pkg::ADDR_PINSEL, 8'h01);
        wr_reg(stt_pkg::ADDR_CTRL0, 8'h19);
        gap(1'b0, n);
        k = n_hi;
        gap(1'b0, n);
        chk("pwm high", 16'h0020, 16'(n_hi - k));
        // static PWM levels, single pulse, compare set and clear, timer mode
        foreach (mcfg[j]) begin
            wr_reg(stt_pkg::ADDR_CTRL0, 8'h00);
            wr_reg(stt_pkg::ADDR_CTRL1, mcfg[j]);
            wr_reg(stt_pkg::ADDR_CTRL0, 8'h19);
            repeat (2) @(posedge sys_clk);
            #1 chk("mode start", 16'(mpre[j]), 16'(out));
            gap(1'b1, n);
            repeat (2) @(posedge sys_clk);
            #1 chk("mode match", 16'(mpost[j]), 16'(out));
        end
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("mid reset", 16'h0008, 16'({out, out_oe, inv, inv_oe, irq_a, irq_p}));
        resetn <= 1'b1;
        rd_reg(stt_pkg::ADDR_CTRL0, v);
        chk("ctrl after reset", 16'h0000, 16'(v));
        final_report();
    end
endmodule
`default_nettype wire
